/* shared/plpr_regs.vh */
`ifndef PLPR_REGS_VH
`define PLPR_REGS_VH
// lock byte field positions
`define PLPR_LOCK_LVL_LO 0
`define PLPR_LOCK_LVL_HI 1
`define PLPR_APP_GUARD_LO 2
`define PLPR_APP_GUARD_HI 3
`define PLPR_BOOT_GUARD_LO 4
`define PLPR_BOOT_GUARD_HI 5
`define PLPR_LOCK_RESET 8'hFF
// page readback geometry
`define PLPR_PAGE_BYTES 128
`define PLPR_PAGE_ABITS 7
`define PLPR_PRELOAD_BITS 8
`define PLPR_FIFO_DEPTH 8
`define PLPR_FIFO_ABITS 3
`endif

/* rtl/plpr_fifo.v */
// the data-path fifo module sits beside the lock logic in plpr_lock.v

/* rtl/plpr_lock.v */
`timescale 1ns/10ps
`include "plpr_regs.vh"
// Overview of operation
// - six lock bits in one byte, top two one
// - stored one means unprogrammed, default all ones
// - only chip erase or reset returns lock bits to one
// - level mode 1 imposes no restriction
// - level mode 2 blocks programming, allows verify
// - level mode 3 blocks programming and verify
// - level modes 2 and 3 lock fuses
// - guard mode 1 leaves store/load free
// - guard mode 2 blocks application-section stores
// - guard mode 3 blocks stores and boot loads
// - guard mode 4 blocks only boot loads
// - modes 3/4 with boot vectors mask interrupts
// - chain length is page bits plus eight
// - internal 8-bit shifter reloaded byte by byte
// - first eight shifts preload, output invalid
// - data out LSB first, first word first
// - shifting follows the test clock
// - locked level refuses debug enable fuse programming
module plpr_lock (
  input wire clk,
  input wire rst,
  input wire lock_write,
  input wire [7:0] lock_write_data,
  input wire chip_erase,
  output wire [7:0] lock_byte,
  output wire [1:0] lock_level_mode,
  output wire [2:0] application_guard_mode,
  input wire prog_req,
  output wire prog_allow,
  input wire verify_req,
  output wire verify_allow,
  input wire fuse_write_req,
  output wire fuse_write_allow,
  input wire debug_fuse_req,
  output wire debug_fuse_allow,
  input wire store_program_memory_op,
  input wire load_program_memory_op,
  input wire target_in_app,
  input wire exec_in_boot,
  output wire store_allow,
  output wire load_allow,
  input wire vectors_in_boot,
  output wire irq_inhibit,
  input wire test_clk,
  input wire page_read_en,
  output reg [`PLPR_PAGE_ABITS-1:0] flash_rd_addr,
  input wire [7:0] flash_rd_data,
  output reg test_data_out,
  output wire [7:0] stream_data,
  output wire stream_valid,
  input wire stream_ready
);
  // ------------------------------------------------------------
  // lock byte storage
  // ------------------------------------------------------------
  localparam [7:0] LOCK_RESET = `PLPR_LOCK_RESET;
  reg [5:0] lock_bits;
  wire lock_level_bit_low;
  wire lock_level_bit_high;
  wire app_guard_bit_low;
  wire app_guard_bit_high;
  assign lock_byte = {LOCK_RESET[7:6], lock_bits};
  assign lock_level_bit_low = lock_bits[`PLPR_LOCK_LVL_LO];
  assign lock_level_bit_high = lock_bits[`PLPR_LOCK_LVL_HI];
  assign app_guard_bit_low = lock_bits[`PLPR_APP_GUARD_LO];
  assign app_guard_bit_high = lock_bits[`PLPR_APP_GUARD_HI];
  // a write can only clear bits; erase or reset is the sole way back to one
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      lock_bits <= LOCK_RESET[5:0];
    else if (chip_erase)
      lock_bits <= LOCK_RESET[5:0];
    else if (lock_write)
      lock_bits <= lock_bits & lock_write_data[5:0];
  end
  // ------------------------------------------------------------
  // programming interface protection
  // ------------------------------------------------------------
  wire lvl_free;
  wire lvl_noverify;
  // encoded 1..3; low-programmed/high-free is mode 2, anything with high programmed is mode 3
  assign lvl_free = lock_level_bit_high && lock_level_bit_low;
  assign lvl_noverify = !lock_level_bit_high;
  assign lock_level_mode = lvl_free ? 2'h1 : (lvl_noverify ? 2'h3 : 2'h2);
  assign prog_allow = prog_req && lvl_free;
  assign verify_allow = verify_req && !lvl_noverify;
  assign fuse_write_allow = fuse_write_req && lvl_free;
  assign debug_fuse_allow = debug_fuse_req && lvl_free;
  // ------------------------------------------------------------
  // self-programming guard
  // ------------------------------------------------------------
  wire [1:0] guard_pair;
  reg [2:0] guard_mode;
  assign guard_pair = {app_guard_bit_high, app_guard_bit_low};
  always @*
  begin
    case (guard_pair)
      2'b11: guard_mode = 3'h1;
      2'b10: guard_mode = 3'h2;
      2'b00: guard_mode = 3'h3;
      default: guard_mode = 3'h4;
    endcase
  end
  assign application_guard_mode = guard_mode;
  wire store_block;
  wire boot_load_block;
  assign store_block = !app_guard_bit_low;
  assign boot_load_block = !app_guard_bit_high;
  assign store_allow = store_program_memory_op && !(target_in_app && store_block);
  assign load_allow = load_program_memory_op && !(target_in_app && exec_in_boot && boot_load_block);
  assign irq_inhibit = boot_load_block && vectors_in_boot && !exec_in_boot;
  // ------------------------------------------------------------
  // test clock synchroniser and edge finding
  // ------------------------------------------------------------
  reg tck_s1;
  reg tck_s2;
  reg tck_s3;
  reg en_s1;
  reg en_s2;
  wire tck_rise;
  wire tck_fall;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tck_s1 <= 1'b0;
      tck_s2 <= 1'b0;
      tck_s3 <= 1'b0;
      en_s1 <= 1'b0;
      en_s2 <= 1'b0;
    end
    else
    begin
      tck_s1 <= test_clk;
      tck_s2 <= tck_s1;
      tck_s3 <= tck_s2;
      en_s1 <= page_read_en;
      en_s2 <= en_s1;
    end
  end
  assign tck_rise = tck_s2 && !tck_s3;
  assign tck_fall = !tck_s2 && tck_s3;
  // ------------------------------------------------------------
  // page fetch into the fifo
  // ------------------------------------------------------------
  // fetches run ahead of the shifter; the fifo stalls them when full
  reg fetching;
  reg fifo_flush;
  wire fifo_in_ready;
  wire fifo_in_valid;
  wire fifo_push;
  wire stream_pop;
  wire allowed;
  assign allowed = en_s2 && !lvl_noverify;
  assign fifo_in_valid = fetching && allowed && !fifo_flush;
  assign fifo_push = fifo_in_valid && fifo_in_ready;
  // the flush is a flop so the fifo's asynchronous clear never sees a decode glitch
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      fifo_flush <= 1'b1;
    else
      fifo_flush <= !allowed;
  end
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fetching <= 1'b0;
      flash_rd_addr <= {`PLPR_PAGE_ABITS{1'b0}};
    end
    else if (!allowed)
    begin
      fetching <= 1'b1;
      flash_rd_addr <= {`PLPR_PAGE_ABITS{1'b0}};
    end
    else if (fifo_push)
    begin
      flash_rd_addr <= flash_rd_addr + 1'b1;
      if (flash_rd_addr == `PLPR_PAGE_BYTES - 1)
        fetching <= 1'b0;
    end
  end
  plpr_fifo #(
    .WIDTH(8),
    .DEPTH(`PLPR_FIFO_DEPTH),
    .ABITS(`PLPR_FIFO_ABITS)
  ) u_fifo (
    .clk(clk),
    .rst(fifo_flush),
    .in_data(flash_rd_data),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data(stream_data),
    .out_valid(stream_valid),
    .out_ready(stream_pop)
  );
  // ------------------------------------------------------------
  // serial shifter
  // ------------------------------------------------------------
  reg [7:0] shifter;
  reg [2:0] bit_cnt;
  reg loaded;
  // a byte leaves the fifo on the rise that closes each eight-bit group
  assign stream_pop = allowed && tck_rise && (bit_cnt == 3'h7) && stream_ready;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      shifter <= 8'h00;
      bit_cnt <= 3'h0;
      loaded <= 1'b0;
    end
    else if (!allowed)
    begin
      shifter <= 8'h00;
      bit_cnt <= 3'h0;
      loaded <= 1'b0;
    end
    else if (tck_rise)
    begin
      bit_cnt <= bit_cnt + 1'b1;
      if (bit_cnt == 3'h7)
      begin
        shifter <= stream_valid ? stream_data : 8'h00;
        loaded <= 1'b1;
      end
      else
        shifter <= {1'b0, shifter[7:1]};
    end
  end
  // update on falling test clock so the programmer samples stable data on the rising edge
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      test_data_out <= 1'b0;
    else if (tck_fall)
      test_data_out <= loaded ? shifter[0] : 1'b0;
  end
endmodule

// ------------------------------------------------------------
// data-path fifo
// ------------------------------------------------------------
module plpr_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter ABITS = 3
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output reg [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [ABITS:0] wr_ptr;
  reg [ABITS:0] rd_ptr;
  wire full;
  wire empty;
  wire do_wr;
  wire do_rd;
  assign full = (wr_ptr[ABITS-1:0] == rd_ptr[ABITS-1:0]) && (wr_ptr[ABITS] != rd_ptr[ABITS]);
  assign empty = (wr_ptr == rd_ptr);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign do_wr = in_valid && !full;
  assign do_rd = out_ready && !empty;
  always @*
  begin
    out_data = mem[rd_ptr[ABITS-1:0]];
  end
  always @(posedge clk)
  begin
    if (do_wr)
      mem[wr_ptr[ABITS-1:0]] <= in_data;
  end
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= {(ABITS+1){1'b0}};
      rd_ptr <= {(ABITS+1){1'b0}};
    end
    else
    begin
      if (do_wr)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_rd)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

/* verification/plpr_lock_properties.sv */
`timescale 1ns/10ps
module plpr_lock_properties (
  input wire clk,
  input wire rst,
  input wire chip_erase,
  input wire [7:0] lock_byte,
  input wire [1:0] lock_level_mode,
  input wire [2:0] application_guard_mode,
  input wire prog_req,
  input wire prog_allow,
  input wire verify_req,
  input wire verify_allow,
  input wire fuse_write_allow,
  input wire store_program_memory_op,
  input wire target_in_app,
  input wire store_allow,
  input wire vectors_in_boot,
  input wire exec_in_boot,
  input wire irq_inhibit,
  input wire debug_fuse_allow,
  input wire load_program_memory_op,
  input wire load_allow,
  input wire stream_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_all_clear;
    lock_byte == 8'hFF;
  endsequence
  a_top_ones: assert property (lock_byte[7:6] == 2'h3)
    else $error("unused lock bits not one");
  a_erase_clears: assert property (chip_erase |=> s_all_clear)
    else $error("erase left lock bits programmed");
  a_clear_only: assert property (!$past(chip_erase) |-> (lock_byte & ~$past(lock_byte)) == 8'h00)
    else $error("lock bit returned to one without erase");
  a_level_map: assert property (lock_level_mode == (lock_byte[1] ? (lock_byte[0] ? 2'h1 : 2'h2) : 2'h3))
    else $error("level mode decode wrong");
  a_mode1_free: assert property (lock_level_mode == 2'h1 |-> prog_allow == prog_req && verify_allow == verify_req)
    else $error("level one restricted access");
  a_mode2_verify: assert property (lock_level_mode == 2'h2 |-> !prog_allow && verify_allow == verify_req)
    else $error("level two access wrong");
  a_mode3_refuse: assert property (lock_level_mode == 2'h3 |-> !prog_allow && !verify_allow)
    else $error("level three let access through");
  a_fuse_lock: assert property (lock_level_mode != 2'h1 |-> !fuse_write_allow)
    else $error("fuse write allowed while locked");
  a_store_guard: assert property (store_program_memory_op && target_in_app |->
    store_allow == (application_guard_mode == 3'h1 || application_guard_mode == 3'h4))
    else $error("store guard wrong");
  a_irq_guard: assert property (vectors_in_boot && !exec_in_boot |-> irq_inhibit == (application_guard_mode > 3'h2))
    else $error("interrupt inhibit wrong");
  a_boot_load: assert property (load_program_memory_op && target_in_app && exec_in_boot |->
    load_allow == (application_guard_mode < 3'h3))
    else $error("boot load guard wrong");
  a_debug_lock: assert property (lock_level_mode != 2'h1 |-> !debug_fuse_allow)
    else $error("debug enable fuse allowed while locked");
  a_locked_stream: assert property (lock_level_mode == 2'h3 |=> !stream_valid)
    else $error("page data queued while fully locked");
endmodule
bind plpr_lock plpr_lock_properties u_props (.*);

/* verification/plpr_flash_model.sv */
`timescale 1ns/10ps
module plpr_flash_model (
  input wire [6:0] addr,
  output wire [7:0] data
);
  // page image is loaded by the bench; read is combinational like the array
  logic [7:0] mem [0:127];
  assign data = mem[addr];
endmodule

/* verification/test_plpr_lock.sv */
`timescale 1ns/10ps
module test_plpr_lock;
  logic clk = 0, rst = 1, lock_write = 0, chip_erase = 0, test_clk = 0, page_read_en = 0, stream_ready = 1;
  logic [7:0] lock_write_data = 8'hFF;
  logic [8:0] rq = 0;
  logic [31:0] lf = 32'h057DAA46;
  logic [7:0] pg[$];
  wire prog_req, verify_req, fuse_write_req, debug_fuse_req, store_program_memory_op, load_program_memory_op;
  wire target_in_app, exec_in_boot, vectors_in_boot, prog_allow, verify_allow, fuse_write_allow, debug_fuse_allow;
  wire store_allow, load_allow, irq_inhibit, test_data_out, stream_valid;
  wire [7:0] lock_byte, flash_rd_data, stream_data;
  wire [6:0] flash_rd_addr;
  wire [2:0] application_guard_mode;
  wire [1:0] lock_level_mode;
  int err_count = 0, compares = 0, lm, gm;
  assign {prog_req, verify_req, fuse_write_req, debug_fuse_req, store_program_memory_op, load_program_memory_op,
    target_in_app, exec_in_boot, vectors_in_boot} = rq;
  plpr_lock u_dut (.*);
  plpr_flash_model u_flash (.addr(flash_rd_addr), .data(flash_rd_data));
  always #20 clk = ~clk;
  function automatic logic [31:0] nxt(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(logic [7:0] d, logic erase);
    @(negedge clk);
    chip_erase = erase;
    lock_write = 1;
    lock_write_data = d;
    @(negedge clk);
    chip_erase = 0;
    lock_write = 0;
    @(negedge clk);
  endtask
  // the test clock idles low and only toggles inside a frame, on falling clk edges
  task automatic readback(int n, logic on);
    @(negedge clk);
    page_read_en = 1;
    stream_ready = 0;
    repeat (20) @(negedge clk);
    chk(stream_valid, on);
    if (on) chk(stream_data, pg[0]);
    stream_ready = 1;
    for (int k = 0; k < n; k++)
    begin
      #160 test_clk = 1;
      if (k >= 8) chk(test_data_out, on ? pg[(k - 8) / 8][(k - 8) % 8] : 1'b0);
      #160 test_clk = 0;
    end
    @(negedge clk);
    page_read_en = 0;
    $display("readback of %0d bits done", n);
  endtask
  initial
  begin
    for (int j = 0; j < 128; j++)
    begin
      lf = nxt(lf);
      pg.push_back(lf[7:0]);
      u_flash.mem[j] = lf[7:0];
    end
    repeat (5) @(negedge clk);
    rst = 0;
    for (int i = 0; i < 16; i++)
    begin
      wr(8'hFF, 1);
      wr({4'hF, i[3:0]}, 0);
      wr(8'hFF, 0);
      lm = i[1] ? (i[0] ? 1 : 2) : 3;
      gm = i[3] ? (i[2] ? 1 : 2) : (i[2] ? 4 : 3);
      chk(lock_byte, {4'hF, i[3:0]});
      chk(lock_level_mode, lm);
      chk(application_guard_mode, gm);
      repeat (16)
      begin
        lf = nxt(lf);
        rq = lf[8:0];
        #1;
        chk(prog_allow, prog_req && lm == 1);
        chk(verify_allow, verify_req && lm != 3);
        chk(fuse_write_allow, fuse_write_req && lm == 1);
        chk(debug_fuse_allow, debug_fuse_req && lm == 1);
        chk(store_allow, store_program_memory_op && (!target_in_app || gm == 1 || gm == 4));
        chk(load_allow, load_program_memory_op && !(target_in_app && exec_in_boot && gm > 2));
        chk(irq_inhibit, vectors_in_boot && !exec_in_boot && gm > 2);
        @(negedge clk);
      end
    end
    $display("lock decode test done");
    readback(1032, 1);
    wr(8'hFC, 0);
    readback(24, 0);
    wr(8'hFF, 1);
    chk(lock_byte, 8'hFF);
    report_and_stop;
  end
  initial
  begin
    #2000000;
    err_count++;
    report_and_stop;
  end
endmodule
